// >>> hdl/sfsb_bank.sv
`timescale 1ns/1ps
module sfsb_bank (
  input wire logic CLK, // 100 MHz clock
  input wire logic SYS_RST, // Async reset, active high
  input wire sfsb_pkg::sfsb_prot_in_type PROT_IN, // Protection comparator results
  input wire sfsb_pkg::sfsb_intg_in_type INTG_IN, // Integrity monitor results
  input wire logic RD_EN, // Host read strobe, one cycle
  input wire logic WR_EN, // Host write strobe, ignored
  input wire logic [0:0] RD_SEL, // Register select
  input wire logic [15:0] WR_DATA, // Host write data, ignored
  output logic [15:0] RD_DATA, // Read data, registered
  output logic [15:0] PROT_STATUS, // Protection word, registered
  output logic [15:0] INTG_STATUS // Integrity word, registered
);

  logic [15:0] prot_q;
  logic [15:0] prot_d;
  logic [15:0] intg_q;
  logic [15:0] intg_d;
  logic [15:0] rd_data_q;
  logic twn_q;
  logic twn_armed_q;
  logic twn_rd;

  // Read of the word holding the warning flag
  assign twn_rd = RD_EN && (RD_SEL == sfsb_pkg::SEL_INTEGRITY);

  always_comb begin
    prot_d = sfsb_pkg::STATUS_RESET;
    prot_d[sfsb_pkg::PROT_OVERTEMP_BIT] = |(PROT_IN.temp_en & PROT_IN.temp_over);
    prot_d[sfsb_pkg::PROT_REGLIM_BIT] = PROT_IN.reg_limit;
    prot_d[sfsb_pkg::PROT_SHORT_BIT] = |(PROT_IN.cur_en & PROT_IN.cur_short);
    prot_d[sfsb_pkg::PROT_OVERCUR_BIT] = |(PROT_IN.cur_en & PROT_IN.cur_over);
    prot_d[sfsb_pkg::PROT_SATLOSS_BIT] = PROT_IN.desat_over;
  end

  always_comb begin
    intg_d = sfsb_pkg::STATUS_RESET;
    intg_d[sfsb_pkg::INTG_VCE_BIT] = INTG_IN.collector_emitter_sense_state;
    intg_d[sfsb_pkg::INTG_TWN_BIT] = twn_q;
    intg_d[sfsb_pkg::INTG_TSD_BIT] = INTG_IN.drv_temp_shut;
    intg_d[sfsb_pkg::INTG_ALARM_OUT_BIT] = INTG_IN.alarm_out;
    intg_d[sfsb_pkg::INTG_WARN_OUT_BIT] = INTG_IN.warn_out;
    intg_d[sfsb_pkg::INTG_BIST_BIT] = INTG_IN.bist_fail;
    intg_d[sfsb_pkg::INTG_CLK_BIT] = INTG_IN.clk_fail;
    intg_d[sfsb_pkg::INTG_CFG_BIT] = INTG_IN.cfg_crc_fail;
    intg_d[sfsb_pkg::INTG_TRIM_BIT] = INTG_IN.trim_crc_fail;
  end

  // Status words follow the monitors and the read-cleared warning latch; host writes have no path here
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prot_q <= sfsb_pkg::STATUS_RESET;
      intg_q <= sfsb_pkg::STATUS_RESET;
    end else begin
      prot_q <= prot_d;
      intg_q <= intg_d;
    end
  end

  // Warning latch: set wins; clear needs cool-down then a later read
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      twn_q <= 1'b0;
      twn_armed_q <= 1'b0;
    end else if (INTG_IN.drv_temp_warn) begin
      twn_q <= 1'b1;
      twn_armed_q <= 1'b0;
    end else if (twn_q && twn_armed_q && twn_rd) begin
      twn_q <= 1'b0;
      twn_armed_q <= 1'b0;
    end else if (twn_q) begin
      twn_armed_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_data_q <= sfsb_pkg::STATUS_RESET;
    end else if (RD_EN) begin
      rd_data_q <= (RD_SEL == sfsb_pkg::SEL_INTEGRITY) ? intg_q : prot_q;
    end
  end

  assign RD_DATA = rd_data_q;
  assign PROT_STATUS = prot_q;
  assign INTG_STATUS = intg_q;

  chk_prot_reserved_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
    prot_q[15:6] == 10'h000 && !prot_q[sfsb_pkg::PROT_RSVD_BIT])
    else $error("Reserved protection bits not zero");

  chk_intg_reserved_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
    intg_q[15] == 1'b0 && intg_q[11] == 1'b0 && intg_q[4:0] == 5'h00)
    else $error("Reserved integrity bits not zero");

  chk_overtemp_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    |(PROT_IN.temp_en & PROT_IN.temp_over) |=> prot_q[sfsb_pkg::PROT_OVERTEMP_BIT])
    else $error("Overtemperature flag missed");

  chk_reglim_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> prot_q[sfsb_pkg::PROT_REGLIM_BIT] == $past(PROT_IN.reg_limit))
    else $error("Regulator limit flag wrong");

  chk_short_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> prot_q[sfsb_pkg::PROT_SHORT_BIT] == |($past(PROT_IN.cur_en) & $past(PROT_IN.cur_short)))
    else $error("Short circuit flag wrong");

  chk_overcur_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> prot_q[sfsb_pkg::PROT_OVERCUR_BIT] == |($past(PROT_IN.cur_en) & $past(PROT_IN.cur_over)))
    else $error("Overcurrent flag wrong");

  chk_desat_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> prot_q[sfsb_pkg::PROT_SATLOSS_BIT] == $past(PROT_IN.desat_over))
    else $error("Saturation loss flag wrong");

  chk_twn_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    twn_q && !twn_rd |=> twn_q)
    else $error("Thermal warning cleared without read");

  chk_twn_set: assert property (@(posedge CLK) disable iff (SYS_RST)
    INTG_IN.drv_temp_warn |=> twn_q ##1 intg_q[sfsb_pkg::INTG_TWN_BIT])
    else $error("Thermal warning not raised");

  chk_write_ignored: assert property (@(posedge CLK) disable iff (SYS_RST)
    WR_EN && !INTG_IN.drv_temp_warn && !twn_q |=> !twn_q)
    else $error("Write disturbed status");

  chk_overtemp_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
    !(|(PROT_IN.temp_en & PROT_IN.temp_over)) |=> !prot_q[sfsb_pkg::PROT_OVERTEMP_BIT])
    else $error("Overtemperature flag without cause");

  chk_disabled_temp: assert property (@(posedge CLK) disable iff (SYS_RST)
    !(|PROT_IN.temp_en) |=> !prot_q[sfsb_pkg::PROT_OVERTEMP_BIT])
    else $error("Disabled temperature input raised flag");

  chk_disabled_cur: assert property (@(posedge CLK) disable iff (SYS_RST)
    !(|PROT_IN.cur_en) |=> !prot_q[sfsb_pkg::PROT_SHORT_BIT] && !prot_q[sfsb_pkg::PROT_OVERCUR_BIT])
    else $error("Disabled current input raised flag");

  // Per-channel detection checks
  for (genvar g = 0; g < sfsb_pkg::NUM_AIN; g++) begin : gen_ain_chk
    chk_ain_overtemp: assert property (@(posedge CLK) disable iff (SYS_RST)
      PROT_IN.temp_en[g] && PROT_IN.temp_over[g] |=> prot_q[sfsb_pkg::PROT_OVERTEMP_BIT])
      else $error("Channel overtemperature missed");

    chk_ain_short: assert property (@(posedge CLK) disable iff (SYS_RST)
      PROT_IN.cur_en[g] && PROT_IN.cur_short[g] |=> prot_q[sfsb_pkg::PROT_SHORT_BIT])
      else $error("Channel short circuit missed");

    chk_ain_overcur: assert property (@(posedge CLK) disable iff (SYS_RST)
      PROT_IN.cur_en[g] && PROT_IN.cur_over[g] |=> prot_q[sfsb_pkg::PROT_OVERCUR_BIT])
      else $error("Channel overcurrent missed");
  end

  // Live integrity flags, one cycle behind the monitors
  chk_sense_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> intg_q[sfsb_pkg::INTG_VCE_BIT] == $past(INTG_IN.collector_emitter_sense_state))
    else $error("Sense state flag wrong");

  chk_shutdown_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> intg_q[sfsb_pkg::INTG_TSD_BIT] == $past(INTG_IN.drv_temp_shut))
    else $error("Thermal shutdown flag wrong");

  chk_mirror_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> intg_q[sfsb_pkg::INTG_ALARM_OUT_BIT] == $past(INTG_IN.alarm_out) &&
      intg_q[sfsb_pkg::INTG_WARN_OUT_BIT] == $past(INTG_IN.warn_out))
    else $error("Fault output mirror wrong");

  chk_selftest_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> intg_q[sfsb_pkg::INTG_BIST_BIT] == $past(INTG_IN.bist_fail))
    else $error("Self test flag wrong");

  chk_monitor_follows: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> intg_q[sfsb_pkg::INTG_CLK_BIT] == $past(INTG_IN.clk_fail) &&
      intg_q[sfsb_pkg::INTG_CFG_BIT] == $past(INTG_IN.cfg_crc_fail) &&
      intg_q[sfsb_pkg::INTG_TRIM_BIT] == $past(INTG_IN.trim_crc_fail))
    else $error("Clock or checksum flag wrong");

  // Warning latch sequencing
  chk_twn_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    twn_q && twn_armed_q && twn_rd && !INTG_IN.drv_temp_warn |=> !twn_q)
    else $error("Thermal warning not cleared by read");

  chk_twn_no_early: assert property (@(posedge CLK) disable iff (SYS_RST)
    twn_q && !twn_armed_q |=> twn_q)
    else $error("Thermal warning cleared too early");

  chk_twn_word: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> intg_q[sfsb_pkg::INTG_TWN_BIT] == $past(twn_q))
    else $error("Thermal warning bit does not follow latch");

  chk_twn_cause: assert property (@(posedge CLK) disable iff (SYS_RST)
    !twn_q && !INTG_IN.drv_temp_warn |=> !twn_q)
    else $error("Thermal warning set without cause");

  // Read port: one word per strobe, held between strobes
  chk_read_prot: assert property (@(posedge CLK) disable iff (SYS_RST)
    RD_EN && RD_SEL == sfsb_pkg::SEL_PROTECTION |=> RD_DATA == $past(prot_q))
    else $error("Protection read data wrong");

  chk_read_intg: assert property (@(posedge CLK) disable iff (SYS_RST)
    RD_EN && RD_SEL == sfsb_pkg::SEL_INTEGRITY |=> RD_DATA == $past(intg_q))
    else $error("Integrity read data wrong");

  chk_read_reserved: assert property (@(posedge CLK) disable iff (SYS_RST)
    RD_EN |=> RD_DATA[15] == 1'b0 && RD_DATA[11] == 1'b0 && RD_DATA[sfsb_pkg::PROT_RSVD_BIT] == 1'b0)
    else $error("Reserved read bits not zero");

  chk_read_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    !RD_EN |=> $stable(RD_DATA))
    else $error("Read data changed without strobe");

  chk_write_no_read: assert property (@(posedge CLK) disable iff (SYS_RST)
    WR_EN && !RD_EN |=> $stable(RD_DATA))
    else $error("Write changed read data");

endmodule

// >>> shared/sfsb_pkg.sv
package sfsb_pkg;

  // Status word layout
  localparam int STATUS_W = 16;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Protection status bit positions
  localparam int PROT_SATLOSS_BIT = 0;
  localparam int PROT_OVERCUR_BIT = 1;
  localparam int PROT_SHORT_BIT = 2;
  localparam int PROT_REGLIM_BIT = 3;
  localparam int PROT_RSVD_BIT = 4;
  localparam int PROT_OVERTEMP_BIT = 5;

  // Integrity status bit positions
  localparam int INTG_TRIM_BIT = 5;
  localparam int INTG_CFG_BIT = 6;
  localparam int INTG_CLK_BIT = 7;
  localparam int INTG_BIST_BIT = 8;
  localparam int INTG_WARN_OUT_BIT = 9;
  localparam int INTG_ALARM_OUT_BIT = 10;
  localparam int INTG_TSD_BIT = 12;
  localparam int INTG_TWN_BIT = 13;
  localparam int INTG_VCE_BIT = 14;

  // Number of switch temperature and current inputs
  localparam int NUM_AIN = 3;

  // Register select codes on the host read port
  localparam logic [0:0] SEL_PROTECTION = 1'h0;
  localparam logic [0:0] SEL_INTEGRITY = 1'h1;

  // Comparator and monitor results feeding the bank
  typedef struct packed {
    logic [NUM_AIN-1:0] temp_en;
    logic [NUM_AIN-1:0] temp_over;
    logic [NUM_AIN-1:0] cur_en;
    logic [NUM_AIN-1:0] cur_short;
    logic [NUM_AIN-1:0] cur_over;
    logic reg_limit;
    logic desat_over;
  } sfsb_prot_in_type;

  typedef struct packed {
    logic collector_emitter_sense_state;
    logic drv_temp_warn;
    logic drv_temp_shut;
    logic alarm_out;
    logic warn_out;
    logic bist_fail;
    logic clk_fail;
    logic cfg_crc_fail;
    logic trim_crc_fail;
  } sfsb_intg_in_type;

endpackage

// >>> sim/sfsb_bank_tb_top.sv
`timescale 1ns/1ps
module sfsb_bank_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  sfsb_pkg::sfsb_prot_in_type prot_in = '0;
  sfsb_pkg::sfsb_intg_in_type intg_in = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [0:0] rd_sel = 1'h0;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rd_data, prot_status, intg_status;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  sfsb_bank i_sfsb_bank (.CLK(clk), .SYS_RST(sys_rst), .PROT_IN(prot_in), .INTG_IN(intg_in), .RD_EN(rd_en),
    .WR_EN(wr_en), .RD_SEL(rd_sel), .WR_DATA(wr_data), .RD_DATA(rd_data), .PROT_STATUS(prot_status),
    .INTG_STATUS(intg_status));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic read(input logic [0:0] sel, output logic [15:0] d);
    rd_en = 1'b1;
    rd_sel = sel;
    cyc(1);
    d = rd_data;
    rd_en = 1'b0;
    cyc(1);
  endtask
  task automatic prot_case(input sfsb_pkg::sfsb_prot_in_type p, input logic [15:0] exp);
    logic [15:0] d;
    prot_in = p;
    wr_en = 1'b1;
    wr_data = 16'hffff;
    cyc(1);
    wr_en = 1'b0;
    check(prot_status, exp);
    read(1'h0, d);
    check(d, exp);
  endtask
  task automatic test_prot();
    prot_case('{temp_en:3'h2, temp_over:3'h2, default:'0}, 16'h0020);
    prot_case('{temp_en:3'h1, temp_over:3'h2, default:'0}, 16'h0000);
    prot_case('{reg_limit:1'b1, default:'0}, 16'h0008);
    prot_case('{cur_en:3'h4, cur_short:3'h4, default:'0}, 16'h0004);
    prot_case('{cur_en:3'h1, cur_over:3'h1, default:'0}, 16'h0002);
    prot_case('{cur_short:3'h7, cur_over:3'h7, default:'0}, 16'h0000);
    prot_case('{desat_over:1'b1, default:'0}, 16'h0001);
    prot_case('1, 16'h002f);
    prot_case('0, 16'h0000);
  endtask
  task automatic test_intg();
    int pos [9] = '{5, 6, 7, 8, 9, 10, 12, 13, 14};
    wr_en = 1'b1;
    wr_data = 16'hffff;
    for (int i = 0; i < 9; i++) begin
      if (i != 7) begin
        intg_in = 9'h001 << i;
        cyc(1);
        check(intg_status, 16'h0001 << pos[i]);
      end
    end
    wr_en = 1'b0;
    intg_in = '0;
    cyc(1);
    check(intg_status, 16'h0000);
    check(rd_data, 16'h0000);
  endtask
  task automatic test_warn();
    logic [15:0] d;
    intg_in.drv_temp_warn = 1'b1;
    cyc(2);
    check(intg_status, 16'h2000);
    read(1'h1, d);
    intg_in.drv_temp_warn = 1'b0;
    read(1'h1, d);
    cyc(2);
    check(intg_status, 16'h2000);
    read(1'h1, d);
    check(d, 16'h2000);
    check(intg_status, 16'h0000);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    logic [15:0] d;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    cyc(1);
    check(prot_status, 16'h0000);
    check(intg_status, 16'h0000);
    read(1'h1, d);
    check(d, 16'h0000);
    test_prot();
    test_intg();
    test_warn();
    stop_test();
  end
endmodule
